/* File: design/frm_top.v */
// retransmit fifo with mailbox bypass registers and input staging fifo
`timescale 1ns/10ps
`include "frm_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module frm_stage_fifo #(
  parameter W = 36,
  parameter D = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst_b,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  localparam integer LAST_I = D - 1;
  localparam [AW:0] FULL_CNT = D[AW:0];
  localparam [AW:0] CNT_ONE = {{AW{1'b0}}, 1'b1};
  localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
  localparam [AW-1:0] LAST = LAST_I[AW-1:0];
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != FULL_CNT);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == LAST) ? {AW{1'b0}} : wp_q + PTR_ONE;
      end
      if (pop) begin
        rp_q <= (rp_q == LAST) ? {AW{1'b0}} : rp_q + PTR_ONE;
      end
      if (push & !pop) begin
        cnt_q <= cnt_q + CNT_ONE;
      end else if (pop & !push) begin
        cnt_q <= cnt_q - CNT_ONE;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module frm_top (
  input wire sys_clk,
  input wire rst_b,
  input wire port_a_clock,
  input wire port_a_chip_select_b,
  input wire port_a_write_read_select,
  input wire port_a_enable,
  input wire mailbox_select_a,
  input wire [`FRM_DATA_W-1:0] port_a_data_bus_in,
  output reg [`FRM_DATA_W-1:0] port_a_data_bus_out_q,
  output reg port_a_data_bus_oe_q,
  input wire port_b_clock,
  input wire port_b_chip_select_b,
  input wire port_b_write_read_select,
  input wire port_b_enable,
  input wire mailbox_select_b,
  input wire [`FRM_DATA_W-1:0] port_b_data_bus_in,
  output reg [`FRM_DATA_W-1:0] port_b_data_bus_out_q,
  output reg port_b_data_bus_oe_q,
  input wire retransmit_mode_in,
  input wire read_from_mark,
  input wire offset_load,
  input wire offset_preset,
  input wire [`FRM_OFS_W-1:0] almost_empty_offset,
  input wire [`FRM_OFS_W-1:0] almost_full_offset,
  output reg input_ready_q,
  output reg almost_full_flag_q,
  output reg output_ready_q,
  output reg almost_empty_flag_q,
  output reg mail_one_full_flag_q,
  output reg mail_two_full_flag_q,
  output reg retransmit_active_q
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: port clocks are sampled, not used as clocks
  reg [`FRM_AVEC_W-1:0] a_s1_q;
  reg [`FRM_AVEC_W-1:0] a_s2_q;
  reg a_clk_d_q;
  reg [`FRM_BVEC_W-1:0] b_s1_q;
  reg [`FRM_BVEC_W-1:0] b_s2_q;
  reg b_clk_d_q;
  reg [`FRM_MISC_W-1:0] m_s1_q;
  reg [`FRM_MISC_W-1:0] m_s2_q;
  reg load_d_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      a_s1_q <= `FRM_AVEC_ZERO;
      a_s2_q <= `FRM_AVEC_ZERO;
      a_clk_d_q <= 1'b0;
      b_s1_q <= `FRM_BVEC_ZERO;
      b_s2_q <= `FRM_BVEC_ZERO;
      b_clk_d_q <= 1'b0;
      m_s1_q <= `FRM_MISC_ZERO;
      m_s2_q <= `FRM_MISC_ZERO;
      load_d_q <= 1'b0;
    end else begin
      a_s1_q <= {port_a_clock, port_a_chip_select_b, port_a_write_read_select,
                 port_a_enable, mailbox_select_a, port_a_data_bus_in};
      a_s2_q <= a_s1_q;
      a_clk_d_q <= a_s2_q[`FRM_VEC_CLK];
      b_s1_q <= {read_from_mark, retransmit_mode_in, port_b_clock,
                 port_b_chip_select_b, port_b_write_read_select,
                 port_b_enable, mailbox_select_b, port_b_data_bus_in};
      b_s2_q <= b_s1_q;
      b_clk_d_q <= b_s2_q[`FRM_VEC_CLK];
      m_s1_q <= {offset_load, offset_preset, almost_empty_offset, almost_full_offset};
      m_s2_q <= m_s1_q;
      load_d_q <= m_s2_q[`FRM_MISC_LOAD];
    end
  end

  // controls travel with their clock through the same two stages
  wire a_edge = a_s2_q[`FRM_VEC_CLK] & ~a_clk_d_q;
  wire a_mb = a_s2_q[`FRM_VEC_MB];
  wire [`FRM_DATA_W-1:0] a_dat = a_s2_q[`FRM_DATA_W-1:0];
  wire a_sel = a_edge & ~a_s2_q[`FRM_VEC_CS] & a_s2_q[`FRM_VEC_EN];
  wire a_wr = a_sel & a_s2_q[`FRM_VEC_WR];
  wire a_rd = a_sel & ~a_s2_q[`FRM_VEC_WR];
  wire b_edge = b_s2_q[`FRM_VEC_CLK] & ~b_clk_d_q;
  wire b_mb = b_s2_q[`FRM_VEC_MB];
  wire [`FRM_DATA_W-1:0] b_dat = b_s2_q[`FRM_DATA_W-1:0];
  wire b_sel = b_edge & ~b_s2_q[`FRM_VEC_CS] & b_s2_q[`FRM_VEC_EN];
  wire b_rd = b_sel & b_s2_q[`FRM_VEC_WR];
  wire b_wr = b_sel & ~b_s2_q[`FRM_VEC_WR];
  wire b_rtm = b_s2_q[`FRM_VEC_RTM];
  wire b_rfm = b_s2_q[`FRM_VEC_RFM];
  wire load_edge = m_s2_q[`FRM_MISC_LOAD] & ~load_d_q;

  //////////////////////////////////////////////////////////////////////////////
  // flag offsets
  reg [`FRM_OFS_W-1:0] ae_ofs_q;
  reg [`FRM_OFS_W-1:0] af_ofs_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ae_ofs_q <= `FRM_OFS_PRESET;
      af_ofs_q <= `FRM_OFS_PRESET;
    end else if (load_edge) begin
      if (m_s2_q[`FRM_MISC_PRE]) begin
        ae_ofs_q <= `FRM_OFS_PRESET;
        af_ofs_q <= `FRM_OFS_PRESET;
      end else begin
        ae_ofs_q <= m_s2_q[2*`FRM_OFS_W-1:`FRM_OFS_W];
        af_ofs_q <= m_s2_q[`FRM_OFS_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write side: staging queue then main array
  reg [`FRM_DATA_W-1:0] mem_q [0:`FRM_DEPTH-1];
  reg [`FRM_PTR_W-1:0] mwp_q;
  reg [`FRM_PTR_W-1:0] wcnt_q;
  wire stg_in_ready;
  wire stg_out_valid;
  wire [`FRM_DATA_W-1:0] stg_out_data;
  // array reads on port B edges take the single array port, so draining stalls
  wire drain_ok = ~b_edge;
  wire fifo_wr = a_wr & ~a_mb & input_ready_q & stg_in_ready;

  frm_stage_fifo #(
    .W(`FRM_DATA_W),
    .D(`FRM_STAGE_DEPTH),
    .AW(`FRM_STAGE_AW)
  ) u_stage (
    .clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(fifo_wr),
    .in_ready(stg_in_ready),
    .in_data(a_dat),
    .out_valid(stg_out_valid),
    .out_ready(drain_ok),
    .out_data(stg_out_data)
  );

  always @(posedge sys_clk) begin
    if (stg_out_valid & drain_ok) begin
      mem_q[mwp_q[`FRM_ADDR_W-1:0]] <= stg_out_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read side pointers and retransmit state
  reg [`FRM_PTR_W-1:0] cur_rd_q;
  reg [`FRM_PTR_W-1:0] cur_rd_d;
  reg [`FRM_PTR_W-1:0] shadow_q;
  reg [`FRM_PTR_W-1:0] wp_s1_q;
  reg [`FRM_PTR_W-1:0] wp_s2_q;
  reg [`FRM_DATA_W-1:0] out_reg_q;
  reg ae_s1_q;
  wire avail = (wp_s2_q != cur_rd_q);
  wire fifo_rd = b_rd & ~b_mb & output_ready_q;
  wire rfm_go = b_edge & retransmit_active_q & b_rfm;
  wire load_out = b_edge & (~output_ready_q | fifo_rd) & avail;
  wire [`FRM_PTR_W-1:0] ae_cnt = mwp_q - cur_rd_d;
  wire ae_raw = (ae_cnt > {1'b0, ae_ofs_q});

  always @* begin
    cur_rd_d = cur_rd_q;
    if (rfm_go) begin
      cur_rd_d = shadow_q + `FRM_PTR_ONE;
    end else if (load_out) begin
      cur_rd_d = cur_rd_q + `FRM_PTR_ONE;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mwp_q <= `FRM_PTR_ZERO;
      wcnt_q <= `FRM_PTR_ZERO;
      cur_rd_q <= `FRM_PTR_ZERO;
      shadow_q <= `FRM_PTR_ZERO;
      wp_s1_q <= `FRM_PTR_ZERO;
      wp_s2_q <= `FRM_PTR_ZERO;
      out_reg_q <= `FRM_DATA_ZERO;
      output_ready_q <= 1'b0;
      ae_s1_q <= 1'b0;
      almost_empty_flag_q <= 1'b0;
      retransmit_active_q <= 1'b0;
    end else begin
      if (stg_out_valid & drain_ok) begin
        mwp_q <= mwp_q + `FRM_PTR_ONE;
      end
      if (fifo_wr) begin
        wcnt_q <= wcnt_q + `FRM_PTR_ONE;
      end
      cur_rd_q <= cur_rd_d;
      if (b_edge) begin
        // two sync stages, word loads on the third edge
        wp_s1_q <= mwp_q;
        wp_s2_q <= wp_s1_q;
        if (rfm_go) begin
          out_reg_q <= mem_q[shadow_q[`FRM_ADDR_W-1:0]];
          output_ready_q <= 1'b1;
        end else if (load_out) begin
          out_reg_q <= mem_q[cur_rd_q[`FRM_ADDR_W-1:0]];
          output_ready_q <= 1'b1;
        end else if (fifo_rd) begin
          output_ready_q <= 1'b0;
        end
        if (!retransmit_active_q & b_rtm & output_ready_q) begin
          retransmit_active_q <= 1'b1;
          // mark the word now in the output register
          shadow_q <= cur_rd_q - `FRM_PTR_ONE;
        end else if (retransmit_active_q & !b_rtm) begin
          // exit edge still obeys the mark pin: rfm_go reloads on it if read_from_mark is high
          retransmit_active_q <= 1'b0;
        end
        // falls at once on a read, rises through two stages
        ae_s1_q <= ae_raw;
        almost_empty_flag_q <= ae_raw ? ae_s1_q : 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write side flags
  // shadow plus one in retransmit, current pointer otherwise
  wire [`FRM_PTR_W-1:0] flag_ptr = retransmit_active_q ? shadow_q + `FRM_PTR_ONE : cur_rd_q;
  reg [`FRM_PTR_W-1:0] fptr_s1_q;
  wire [`FRM_PTR_W-1:0] wcnt_d = fifo_wr ? wcnt_q + `FRM_PTR_ONE : wcnt_q;
  // mark reloads assume at least two reads were made past it
  wire [`FRM_PTR_W-1:0] a_cnt = wcnt_d - fptr_s1_q;
  wire [`FRM_PTR_W-1:0] af_lim = `FRM_DEPTH - {1'b0, af_ofs_q};
  // full at the 1024th write past the mark
  wire ir_raw = (a_cnt < `FRM_DEPTH);
  // almost full at depth minus offset
  wire af_raw = (a_cnt < af_lim);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fptr_s1_q <= `FRM_PTR_ZERO;
      input_ready_q <= 1'b0;
      almost_full_flag_q <= 1'b0;
    end else begin
      if (a_edge) begin
        // pointer taken only at a later port A edge
        fptr_s1_q <= flag_ptr;
        // second port A edge shows the rise
        input_ready_q <= ir_raw;
        almost_full_flag_q <= af_raw;
      end else if (fifo_wr) begin
        input_ready_q <= ir_raw;
        almost_full_flag_q <= af_raw;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // mailboxes
  reg [`FRM_DATA_W-1:0] mail_one_q;
  reg [`FRM_DATA_W-1:0] mail_two_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mail_one_q <= `FRM_DATA_ZERO;
      mail_two_q <= `FRM_DATA_ZERO;
      mail_one_full_flag_q <= 1'b1;
      mail_two_full_flag_q <= 1'b1;
    end else begin
      // contents change only on accepted writes
      // full flag low, writes ignored while low; new mail wins a tie
      if (a_wr & a_mb & mail_one_full_flag_q) begin
        mail_one_q <= a_dat;
        mail_one_full_flag_q <= 1'b0;
      end else if (b_rd & b_mb) begin
        // port B mail read empties mail one
        mail_one_full_flag_q <= 1'b1;
      end
      if (b_wr & b_mb & mail_two_full_flag_q) begin
        mail_two_q <= b_dat;
        mail_two_full_flag_q <= 1'b0;
      end else if (a_rd & a_mb) begin
        // port A mail read empties mail two
        mail_two_full_flag_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data outputs; enables follow the synchronised selects, so lag the pins
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_a_data_bus_out_q <= `FRM_DATA_ZERO;
      port_a_data_bus_oe_q <= 1'b0;
      port_b_data_bus_out_q <= `FRM_DATA_ZERO;
      port_b_data_bus_oe_q <= 1'b0;
    end else begin
      // port A always shows mail two
      port_a_data_bus_out_q <= mail_two_q;
      port_a_data_bus_oe_q <= ~a_s2_q[`FRM_VEC_CS] & ~a_s2_q[`FRM_VEC_WR];
      // mailbox select picks mail one or fifo output
      port_b_data_bus_out_q <= b_mb ? mail_one_q : out_reg_q;
      port_b_data_bus_oe_q <= ~b_s2_q[`FRM_VEC_CS] & b_s2_q[`FRM_VEC_WR];
    end
  end

endmodule

/* File: pkg/frm_regs.vh */
// constants for the retransmit fifo and mailbox block
`ifndef FRM_REGS_VH
`define FRM_REGS_VH
`define FRM_DATA_W 36
`define FRM_PTR_W 11
`define FRM_ADDR_W 10
`define FRM_OFS_W 10
`define FRM_DEPTH 11'h400
`define FRM_PTR_ONE 11'h001
`define FRM_PTR_ZERO 11'h000
`define FRM_DATA_ZERO 36'h000000000
`define FRM_OFS_PRESET 10'h008
`define FRM_STAGE_DEPTH 32
`define FRM_STAGE_AW 5
`define FRM_VEC_CLK 40
`define FRM_VEC_CS 39
`define FRM_VEC_WR 38
`define FRM_VEC_EN 37
`define FRM_VEC_MB 36
`define FRM_AVEC_W 41
`define FRM_VEC_RTM 41
`define FRM_VEC_RFM 42
`define FRM_BVEC_W 43
`define FRM_MISC_LOAD 21
`define FRM_MISC_PRE 20
`define FRM_MISC_W 22
`define FRM_AVEC_ZERO 41'h00000000000
`define FRM_BVEC_ZERO 43'h00000000000
`define FRM_MISC_ZERO 22'h000000
`endif

/* File: test/frm_port_bfm.sv */
// port master model: free-running port clock and one bus cycle per clock
`timescale 1ns/10ps
module frm_port_bfm #(
  parameter H = 6
) (
  input wire sys_clk,
  input wire gate,
  output wire pclk,
  output wire pre,
  output reg cs_b = 1'b1,
  output reg wr = 1'b0,
  output reg en = 1'b0,
  output reg mb = 1'b0,
  output reg [1:0] aux = 2'h0,
  output reg [35:0] dat = 36'h0
);
  reg [4:0] cnt_q = 5'h00;
  assign pclk = cnt_q >= H;
  assign pre = cnt_q == H - 1;
  always @(posedge sys_clk) begin
    cnt_q <= (cnt_q == 2 * H - 1) ? 5'h00 : cnt_q + 5'h01;
  end
  // changing at the fall gives half a period of setup and of hold
  task op(input c, input w, input e, input m, input [1:0] x, input [35:0] d, output g);
    do @(posedge sys_clk); while (cnt_q != 2 * H - 1);
    g = gate;
    cs_b <= c;
    wr <= w;
    en <= e;
    mb <= m;
    aux <= x;
    // a deselected bus inverts its pattern each cycle, so it shows the last word every other cycle
    dat <= c ? ~dat : d;
  endtask
endmodule

/* File: test/frm_top_props.sv */
// port-level assertions for the retransmit fifo and mailbox block
`timescale 1ns/10ps
module frm_top_props (
  input wire sys_clk,
  input wire rst_b,
  input wire port_a_chip_select_b,
  input wire port_a_write_read_select,
  input wire port_a_enable,
  input wire mailbox_select_a,
  input wire port_b_chip_select_b,
  input wire port_b_write_read_select,
  input wire port_b_enable,
  input wire mailbox_select_b,
  input wire retransmit_mode_in,
  input wire [35:0] port_a_data_bus_out_q,
  input wire [35:0] port_b_data_bus_out_q,
  input wire output_ready_q,
  input wire almost_empty_flag_q,
  input wire almost_full_flag_q,
  input wire mail_one_full_flag_q,
  input wire mail_two_full_flag_q,
  input wire retransmit_active_q
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // pins are judged where the synchroniser took them, three samples before the flag moved;
  // the contract lets them change soon after the port clock rise
  mail_one_wr_a: assert property ($fell(mail_one_full_flag_q) |->
    !$past(port_a_chip_select_b, 3) && $past(port_a_write_read_select, 3)
    && $past(port_a_enable, 3) && $past(mailbox_select_a, 3))
    else $error("mail one flag fell without a port a mail write");
  mail_two_wr_a: assert property ($fell(mail_two_full_flag_q) |->
    !$past(port_b_chip_select_b, 3) && !$past(port_b_write_read_select, 3)
    && $past(port_b_enable, 3) && $past(mailbox_select_b, 3))
    else $error("mail two flag fell without a port b mail write");
  mail_one_rd_a: assert property ($rose(mail_one_full_flag_q) |->
    !$past(port_b_chip_select_b, 3) && $past(port_b_write_read_select, 3)
    && $past(port_b_enable, 3) && $past(mailbox_select_b, 3))
    else $error("mail one flag rose without a port b mail read");
  mail_two_rd_a: assert property ($rose(mail_two_full_flag_q) |->
    !$past(port_a_chip_select_b, 3) && !$past(port_a_write_read_select, 3)
    && $past(port_a_enable, 3) && $past(mailbox_select_a, 3))
    else $error("mail two flag rose without a port a mail read");
  // eight cycles cover the select synchroniser plus the output register
  mail_one_keep_a: assert property ((mailbox_select_b && mail_one_full_flag_q)[*8] |->
    $stable(port_b_data_bus_out_q)) else $error("port b mail data moved without a write");
  mail_two_keep_a: assert property (mail_two_full_flag_q[*3] |->
    $stable(port_a_data_bus_out_q)) else $error("port a data moved without a mail write");
  rt_enter_a: assert property ($rose(retransmit_active_q) |->
    $past(retransmit_mode_in, 3) && $past(output_ready_q))
    else $error("retransmit entered wrongly");
  rt_leave_a: assert property ($fell(retransmit_active_q) |-> !$past(retransmit_mode_in, 3))
    else $error("retransmit left with mode high");
  ae_needs_or_a: assert property (almost_empty_flag_q |-> output_ready_q)
    else $error("almost empty high with no word ready");
  reset_state_a: assert property ($rose(rst_b) |->
    mail_one_full_flag_q && mail_two_full_flag_q && !retransmit_active_q)
    else $error("state after reset wrong");
  cover property ($rose(retransmit_active_q));
  cover property ($fell(mail_one_full_flag_q));
  cover property ($fell(almost_full_flag_q));
endmodule
bind frm_top frm_top_props u_frm_top_props (.*);

/* File: test/frm_top_tb.sv */
// self-checking bench for the retransmit fifo and mailbox block
`timescale 1ns/10ps
`include "frm_regs.vh"
module frm_top_tb;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  wire port_a_clock, port_a_chip_select_b, port_a_write_read_select, port_a_enable;
  wire mailbox_select_a, port_b_clock, port_b_chip_select_b, port_b_write_read_select;
  wire port_b_enable, mailbox_select_b, retransmit_mode_in, read_from_mark;
  wire [`FRM_DATA_W-1:0] port_a_data_bus_in, port_b_data_bus_in;
  wire [`FRM_DATA_W-1:0] port_a_data_bus_out_q, port_b_data_bus_out_q;
  wire port_a_data_bus_oe_q, port_b_data_bus_oe_q, input_ready_q, almost_full_flag_q;
  wire output_ready_q, almost_empty_flag_q, mail_one_full_flag_q, mail_two_full_flag_q;
  wire retransmit_active_q, a_pre, b_pre;
  wire [1:0] a_aux;
  reg offset_load = 1'b0;
  reg offset_preset = 1'b0;
  reg [9:0] almost_empty_offset = 10'h008;
  reg [9:0] almost_full_offset = 10'h008;
  reg [31:0] lfsr = 32'h1d2b3047;
  reg [35:0] qa[$];
  reg [35:0] qb[$];
  reg [35:0] mem [0:11];
  integer n_fail = 0;
  integer checks = 0;
  always #5 sys_clk = ~sys_clk;
  frm_top u_frm_top (.*);
  frm_port_bfm #(.H(6)) u_frm_port_bfm (.sys_clk(sys_clk), .gate(input_ready_q),
    .pclk(port_a_clock), .pre(a_pre), .cs_b(port_a_chip_select_b),
    .wr(port_a_write_read_select), .en(port_a_enable), .mb(mailbox_select_a),
    .aux(a_aux), .dat(port_a_data_bus_in));
  frm_port_bfm #(.H(7)) u_frm_port_bfm_b (.sys_clk(sys_clk), .gate(output_ready_q),
    .pclk(port_b_clock), .pre(b_pre), .cs_b(port_b_chip_select_b),
    .wr(port_b_write_read_select), .en(port_b_enable), .mb(mailbox_select_b),
    .aux({read_from_mark, retransmit_mode_in}), .dat(port_b_data_bus_in));
  ////////////////////////////////////////
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task rnd(output [35:0] v);
    lfsr = lfsr_next(lfsr);
    v = {lfsr[3:0], lfsr};
  endtask
  task chk(input [35:0] seen, input [35:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task take(input [35:0] seen, input b);
    if ((b ? qb.size() : qa.size()) == 0) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t seen %h expected none", $time, seen);
    end else if (b) begin
      chk(seen, qb.pop_front());
    end else begin
      chk(seen, qa.pop_front());
    end
  endtask
  task wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // reads are judged just before the taking edge, against the oldest note
  always @(posedge sys_clk) begin
    if (b_pre && !port_b_chip_select_b && port_b_write_read_select && port_b_enable
        && (mailbox_select_b || output_ready_q === 1'b1)) begin
      take(port_b_data_bus_out_q, 1'b1);
      chk(port_b_data_bus_oe_q, 1'b1);
    end
    if (a_pre && !port_a_chip_select_b && !port_a_write_read_select && port_a_enable
        && mailbox_select_a) begin
      take(port_a_data_bus_out_q, 1'b0);
      chk(port_a_data_bus_oe_q, 1'b1);
    end
  end
  task rd(input [35:0] d, input [1:0] x);
    reg g;
    qb.push_back(d);
    u_frm_port_bfm_b.op(0, 1, 1, 0, x, 0, g);
  endtask
  ////////////////////////////////////////
  initial begin : main
    reg [35:0] v;
    reg g;
    integer i;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({mail_one_full_flag_q, mail_two_full_flag_q, retransmit_active_q}, 3'h6);
    rnd(v);
    qb.push_back(v);
    qb.push_back(v);
    u_frm_port_bfm.op(0, 1, 1, 1, 0, v, g);
    rnd(v);
    u_frm_port_bfm.op(0, 1, 1, 1, 0, v, g);
    u_frm_port_bfm.op(1, 0, 0, 0, 0, v, g);
    chk(mail_one_full_flag_q, 0);
    u_frm_port_bfm_b.op(0, 1, 1, 1, 0, 0, g);
    u_frm_port_bfm_b.op(0, 1, 1, 1, 0, 0, g);
    u_frm_port_bfm_b.op(1, 0, 0, 1, 0, 0, g);
    chk(mail_one_full_flag_q, 1);
    qa.push_back(v);
    u_frm_port_bfm_b.op(0, 0, 1, 1, 0, v, g);
    u_frm_port_bfm_b.op(1, 0, 0, 0, 0, 0, g);
    chk(mail_two_full_flag_q, 0);
    u_frm_port_bfm.op(0, 0, 1, 1, 0, v, g);
    u_frm_port_bfm.op(1, 0, 0, 0, 0, v, g);
    chk(mail_two_full_flag_q, 1);
    // preset must win over the offset pins
    almost_empty_offset <= 10'h3ff;
    offset_preset <= 1'b1;
    offset_load <= 1'b1;
    repeat (4) @(posedge sys_clk);
    offset_load <= 1'b0;
    for (i = 0; i < 12; i = i + 1) begin
      rnd(mem[i]);
      u_frm_port_bfm.op(0, 1, 1, 0, 0, mem[i], g);
    end
    u_frm_port_bfm.op(1, 0, 0, 0, 0, v, g);
    repeat (6) u_frm_port_bfm_b.op(1, 0, 0, 0, 0, 0, g);
    chk({output_ready_q, almost_empty_flag_q}, 2'h3);
    for (i = 0; i < 3; i = i + 1) rd(mem[i], 2'b00);
    u_frm_port_bfm_b.op(1, 0, 0, 0, 2'b01, 0, g);
    for (i = 3; i < 6; i = i + 1) rd(mem[i], 2'b01);
    // reload only after reads past the mark
    u_frm_port_bfm_b.op(1, 0, 0, 0, 2'b11, 0, g);
    chk(retransmit_active_q, 1);
    for (i = 3; i < 12; i = i + 1) rd(mem[i], 2'b01);
    // reload input low on the leaving edge
    repeat (2) u_frm_port_bfm_b.op(1, 0, 0, 0, 2'b00, 0, g);
    chk({retransmit_active_q, output_ready_q, almost_empty_flag_q}, 0);
    for (i = 0; i < 1100; i = i + 1) begin
      if (qb.size() == 1020) chk({input_ready_q, almost_full_flag_q}, 2'h2);
      rnd(v);
      u_frm_port_bfm.op(0, 1, 1, 0, 0, v, g);
      if (g === 1'b1) qb.push_back(v);
    end
    u_frm_port_bfm.op(1, 0, 0, 0, 0, v, g);
    chk({input_ready_q, almost_full_flag_q}, 0);
    // random enables stall the reader while the buffer drains
    for (i = 0; i < 4000 && qb.size() > 0; i = i + 1) begin
      rnd(v);
      u_frm_port_bfm_b.op(0, 1, v[0], 0, 0, 0, g);
    end
    repeat (3) u_frm_port_bfm_b.op(0, 1, 1, 0, 0, 0, g);
    u_frm_port_bfm_b.op(1, 0, 0, 0, 0, 0, g);
    repeat (3) u_frm_port_bfm.op(1, 0, 0, 0, 0, v, g);
    chk({input_ready_q, output_ready_q, almost_empty_flag_q}, 3'h4);
    chk(qb.size(), 0);
    chk({port_a_data_bus_oe_q, port_b_data_bus_oe_q}, 2'h0);
    // stale mail must not survive a reset in mid-run
    u_frm_port_bfm.op(0, 1, 1, 1, 0, v, g);
    u_frm_port_bfm.op(1, 0, 0, 0, 0, v, g);
    chk(mail_one_full_flag_q, 0);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({mail_one_full_flag_q, mail_two_full_flag_q, retransmit_active_q}, 3'h6);
    wrap_up;
  end
  initial begin : watchdog
    repeat (80000) @(posedge sys_clk);
    n_fail = n_fail + 1;
    wrap_up;
  end
endmodule
